// ---- pfc_pkg.sv ----
// package: register map, field layout and types for the protection fet control
package pfc_pkg;
    // register byte offsets
    localparam logic [5:0] OFF_CTRL      = 6'h00;
    localparam logic [5:0] OFF_PRE_LIM   = 6'h04;
    localparam logic [5:0] OFF_UV_LIM    = 6'h08;
    localparam logic [5:0] OFF_CUT_LIM   = 6'h0C;
    localparam logic [5:0] OFF_HYST      = 6'h10;
    localparam logic [5:0] OFF_TEMP_LIM  = 6'h14;
    localparam logic [5:0] OFF_CUR_LIM   = 6'h18;
    localparam logic [5:0] OFF_DELAY     = 6'h1C;
    localparam logic [5:0] OFF_STATUS    = 6'h20;
    localparam logic [5:0] OFF_IRQ_STAT  = 6'h24;
    localparam logic [5:0] OFF_IRQ_MASK  = 6'h28;
    localparam logic [5:0] OFF_SYS_LIM   = 6'h2C;

    // control register fields
    localparam int CTRL_FORCE_POL_LSB = 0;  // two polarity bits
    localparam int CTRL_BAL_NO_DSG    = 2;
    localparam int CTRL_BAL_NO_CHG    = 3;
    localparam int CTRL_HIGH_AVAIL    = 4;
    localparam int CTRL_ENABLE        = 5;

    // reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0020;
    localparam logic [31:0] LIMIT_RST   = 32'h0000_0000;
    localparam logic [31:0] DELAY_RST   = 32'h0000_000A;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // interrupt event bit positions
    localparam int EV_CELL_UV  = 0;
    localparam int EV_CUTOFF   = 1;
    localparam int EV_TEMP     = 2;
    localparam int EV_CURRENT  = 3;
    localparam int EV_HW_TRIP  = 4;
    localparam int EV_EXTERNAL = 5;
    localparam int EV_SYS_OV   = 6;
    localparam int NUM_EV      = 7;

    // debounce time constants, unused; the timers count clocks from dly, reset to DELAY_RST (10 cycles)
    localparam int  DELAY_US     = 10;
    localparam int  CLK_MHZ      = 100;
    localparam int  DELAY_CYC    = DELAY_US * CLK_MHZ;

    // balancing pump duty, in percent of time
    localparam logic [6:0] PUMP_DUTY_NORM = 7'd30;
    localparam logic [6:0] PUMP_DUTY_HIGH = 7'd65;
    localparam logic [6:0] PUMP_PERIOD    = 7'd100;

    typedef enum logic [1:0] {
        PFC_IDLE,
        PFC_CHARGE,
        PFC_DISCHARGE
    } pfc_dir_e;

    // switch drive group
    typedef struct packed {
        logic precharge;
        logic charge;
        logic discharge;
    } pfc_drive_s;

    // measurement group
    typedef struct packed {
        logic [15:0] min_cell;
        logic [15:0] max_cell;
        logic [15:0] pack_volt;
        logic [15:0] temp;
        logic [15:0] current;   // signed, positive = charging
    } pfc_meas_s;
endpackage : pfc_pkg

// ---- pfc_fet_ctrl.sv ----
// module: protection switch decision logic with avalon-mm register slave
//
// Behaviour
// - below precharge, undervoltage or temperature limit: precharge on, charge off
// - all cells above limit and warm enough: charge drive on as well
// - cell at cutoff or temperature trip: charge and precharge both off
// - while charging above thresholds, discharge drive also enabled
// - while discharging, charge drive on only with correct current, no fault
// - discharge drive defaults high when no fault present
// - discharge drive low on cell undervoltage, discharge overcurrent or a cutoff, temperature or system overvoltage fault
// - programmable hysteresis on system and cell over/undervoltage compares
// - each temperature and current threshold has its own delay timer
// - configurable polarity of each external force input
// - asserted external force input turns protection switches off
// - hardware overcurrent/short detectors open switches directly
// - two options suppress balancing: one in discharge, one in charge
// - high availability mode raises pump duty when idle with no fault, disables temperature rate rise
`timescale 1ns/1ns
module pfc_fet_ctrl
    import pfc_pkg::*;
#(
    parameter int NUM_FORCE = 2,
    parameter int DLY_W     = 16
) (
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    // avalon-mm slave
    input  wire logic [5:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output      logic [31:0]          avs_readdata,
    output      logic                 avs_waitrequest,
    // measurements and detectors
    input  wire pfc_meas_s            meas_i,
    input  wire logic                 hw_overcurrent_i,
    input  wire logic                 hw_short_i,
    input  wire logic [NUM_FORCE-1:0] external_switch_force_in_i,
    // outputs
    output      pfc_drive_s           drive_o,
    output      logic                 balance_en_o,
    output      logic                 pump_on_o,
    output      logic                 temp_rate_en_o,
    output      logic                 irq_o
);
    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [31:0] ctrl, pre_lim, uv_lim, cut_lim, hyst, temp_lim, cur_lim;
    logic [31:0] dly, sys_lim;
    logic [NUM_EV-1:0] irq_stat, irq_mask, ev;
    logic        rd_pend;

    // byte lane merge used by every writable register except irq_mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // writes take effect the cycle they are seen; reads wait one cycle
    assign avs_waitrequest = !ce_i || (avs_read && !rd_pend);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl     <= CTRL_RST;
            pre_lim  <= LIMIT_RST;
            uv_lim   <= LIMIT_RST;
            cut_lim  <= LIMIT_RST;
            hyst     <= LIMIT_RST;
            temp_lim <= LIMIT_RST;
            cur_lim  <= LIMIT_RST;
            dly      <= DELAY_RST;
            sys_lim  <= LIMIT_RST;
            irq_mask <= '0;
        end else if (ce_i && avs_write) begin
            unique case (avs_address)
                OFF_CTRL:     ctrl     <= merge(ctrl, avs_writedata,
                                                avs_byteenable);
                OFF_PRE_LIM:  pre_lim  <= merge(pre_lim, avs_writedata,
                                                avs_byteenable);
                OFF_UV_LIM:   uv_lim   <= merge(uv_lim, avs_writedata,
                                                avs_byteenable);
                OFF_CUT_LIM:  cut_lim  <= merge(cut_lim, avs_writedata,
                                                avs_byteenable);
                OFF_HYST:     hyst     <= merge(hyst, avs_writedata,
                                                avs_byteenable);
                OFF_TEMP_LIM: temp_lim <= merge(temp_lim, avs_writedata,
                                                avs_byteenable);
                OFF_CUR_LIM:  cur_lim  <= merge(cur_lim, avs_writedata,
                                                avs_byteenable);
                OFF_DELAY:    dly      <= merge(dly, avs_writedata,
                                                avs_byteenable);
                OFF_SYS_LIM:  sys_lim  <= merge(sys_lim, avs_writedata,
                                                avs_byteenable);
                OFF_IRQ_MASK: irq_mask <= avs_writedata[NUM_EV-1:0];
                default: ;
            endcase
        end
    end

    //------------------------------------------------------------------
    // comparisons with hysteresis
    //------------------------------------------------------------------
    // field use: lim[15:0] low threshold except cut_lim[15:0], which is high; sys_lim[31:16] high threshold
    logic uv_flt, pre_flt, cut_flt, sys_ov_flt, sys_uv_flt;
    logic cold_raw, hot_raw, ocd_raw, occ_raw;
    logic cold_flt, hot_flt, ocd_flt, occ_flt;
    logic [15:0] h;
    assign h = hyst[15:0];

    // latch a fault past threshold, release only past threshold plus margin
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uv_flt     <= 1'b0;
            pre_flt    <= 1'b0;
            cut_flt    <= 1'b0;
            sys_ov_flt <= 1'b0;
            sys_uv_flt <= 1'b0;
        end else if (ce_i) begin
            if (meas_i.min_cell < uv_lim[15:0]) begin
                uv_flt <= 1'b1;
            end else if (meas_i.min_cell >= {1'b0, uv_lim[15:0]} + h) begin
                uv_flt <= 1'b0;
            end
            if (meas_i.min_cell < pre_lim[15:0]) begin
                pre_flt <= 1'b1;
            end else if (meas_i.min_cell >= {1'b0, pre_lim[15:0]} + h) begin
                pre_flt <= 1'b0;
            end
            if (meas_i.max_cell >= cut_lim[15:0]) begin
                cut_flt <= 1'b1;
            end else if ({1'b0, meas_i.max_cell} + h < cut_lim[15:0]) begin
                cut_flt <= 1'b0;
            end
            if (meas_i.pack_volt >= sys_lim[31:16]) begin
                sys_ov_flt <= 1'b1;
            end else if ({1'b0, meas_i.pack_volt} + h < sys_lim[31:16]) begin
                sys_ov_flt <= 1'b0;
            end
            if (meas_i.pack_volt < sys_lim[15:0]) begin
                sys_uv_flt <= 1'b1;
            end else if (meas_i.pack_volt >= {1'b0, sys_lim[15:0]} + h) begin
                sys_uv_flt <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // per-threshold delay timers
    //------------------------------------------------------------------
    // temp_lim: [15:0] min charge temperature, [31:16] trip temperature
    // cur_lim:  [15:0] discharge limit magnitude, [31:16] charge limit
    assign cold_raw = meas_i.temp < temp_lim[15:0];
    assign hot_raw  = meas_i.temp >= temp_lim[31:16];
    assign ocd_raw  = $signed(meas_i.current) < -$signed({1'b0, cur_lim[15:0]});
    assign occ_raw  = $signed({1'b0, meas_i.current}) >
                      $signed({1'b0, cur_lim[31:16]}) &&
                      !meas_i.current[15];

    logic [3:0] raw_v, flt_v;
    assign raw_v = {occ_raw, ocd_raw, hot_raw, cold_raw};
    assign {occ_flt, ocd_flt, hot_flt, cold_flt} = flt_v;

    // independent counters: a crossing must persist the full delay
    generate
        for (genvar g = 0; g < 4; g++) begin : g_tmr
            logic [DLY_W-1:0] cnt;
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    cnt      <= '0;
                    flt_v[g] <= 1'b0;
                end else if (ce_i) begin
                    if (!raw_v[g]) begin
                        cnt      <= '0;
                        flt_v[g] <= 1'b0;
                    end else if (cnt >= dly[DLY_W-1:0]) begin
                        flt_v[g] <= 1'b1;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // external force inputs and hardware trip
    //------------------------------------------------------------------
    logic [NUM_FORCE-1:0] pol;
    logic ext_force, hw_trip;
    assign pol       = ctrl[CTRL_FORCE_POL_LSB +: NUM_FORCE];
    // pol bit 1 means active high
    assign ext_force = |(~(external_switch_force_in_i ^ pol));
    // bypasses timers and firmware state entirely
    assign hw_trip   = hw_overcurrent_i | hw_short_i;

    //------------------------------------------------------------------
    // switch decision
    //------------------------------------------------------------------
    pfc_dir_e dir;
    logic safety, chg_ok, pre_req, next_pre, next_chg, next_dsg, forced;

    always_comb begin
        if (!meas_i.current[15] && meas_i.current != '0) begin
            dir = PFC_CHARGE;
        end else if (meas_i.current[15]) begin
            dir = PFC_DISCHARGE;
        end else begin
            dir = PFC_IDLE;
        end
    end

    assign safety = cut_flt | hot_flt | sys_ov_flt | occ_flt | ocd_flt
                    | uv_flt | sys_uv_flt;
    assign forced = hw_trip | ext_force | !ctrl[CTRL_ENABLE];
    assign pre_req = pre_flt | uv_flt | cold_flt;
    assign chg_ok  = !pre_req && !cut_flt && !hot_flt
                     && !sys_ov_flt && !occ_flt;

    always_comb begin
        next_pre = 1'b1;
        next_chg = chg_ok;
        next_dsg = 1'b1;
        if (pre_req) begin
            next_chg = 1'b0;
        end
        // in discharge the charge switch keeps chg_ok, dropped also on ocd_flt or uv_flt, so its diode does not heat
        if (dir == PFC_DISCHARGE && (ocd_flt || uv_flt)) begin
            next_chg = 1'b0;
        end
        if (uv_flt || sys_uv_flt || ocd_flt || cut_flt
            || hot_flt || sys_ov_flt) begin
            next_dsg = dir == PFC_CHARGE && !cut_flt && !hot_flt
                       && !sys_ov_flt && !occ_flt && !pre_req;
            if (dir != PFC_CHARGE) begin
                next_dsg = 1'b0;
            end
        end
        if (ocd_flt) begin
            next_dsg = 1'b0;
        end
        if (cut_flt || hot_flt) begin
            next_pre = 1'b0;
            next_chg = 1'b0;
        end
        if (forced) begin
            next_pre = 1'b0;
            next_chg = 1'b0;
            next_dsg = 1'b0;
        end
    end

    // registered drives; reset holds every switch off
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drive_o <= '0;
        end else if (ce_i) begin
            drive_o.precharge <= next_pre;
            drive_o.charge    <= next_chg;
            drive_o.discharge <= next_dsg;
        end
    end

    //------------------------------------------------------------------
    // balancing control
    //------------------------------------------------------------------
    logic [6:0] pump_cnt, duty;
    logic high_avail;
    assign high_avail = ctrl[CTRL_HIGH_AVAIL] && !safety
                        && dir == PFC_IDLE;
    assign duty = high_avail ? PUMP_DUTY_HIGH : PUMP_DUTY_NORM;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pump_cnt       <= '0;
            pump_on_o      <= 1'b0;
            balance_en_o   <= 1'b0;
            temp_rate_en_o <= 1'b1;
        end else if (ce_i) begin
            pump_cnt <= (pump_cnt == PUMP_PERIOD - 7'd1) ? '0
                        : pump_cnt + 7'd1;
            balance_en_o <= !(ctrl[CTRL_BAL_NO_DSG] && dir == PFC_DISCHARGE)
                            && !(ctrl[CTRL_BAL_NO_CHG]
                                 && dir == PFC_CHARGE);
            pump_on_o <= balance_en_o && pump_cnt < duty;
            // rate-of-rise not offered while mode is selected
            temp_rate_en_o <= !ctrl[CTRL_HIGH_AVAIL];
        end
    end

    //------------------------------------------------------------------
    // interrupts: sticky, cleared by read, set wins over clear
    //------------------------------------------------------------------
    assign ev[EV_CELL_UV]  = uv_flt;
    assign ev[EV_CUTOFF]   = cut_flt;
    assign ev[EV_TEMP]     = hot_flt | cold_flt;
    assign ev[EV_CURRENT]  = ocd_flt | occ_flt;
    assign ev[EV_HW_TRIP]  = hw_trip;
    assign ev[EV_EXTERNAL] = ext_force;
    assign ev[EV_SYS_OV]   = sys_ov_flt | sys_uv_flt;

    logic stat_rd;
    assign stat_rd = avs_read && rd_pend && avs_address == OFF_IRQ_STAT;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat <= '0;
        end else if (ce_i) begin
            irq_stat <= (stat_rd ? '0 : irq_stat) | ev;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    //------------------------------------------------------------------
    // read path
    //------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_pend      <= 1'b0;
            avs_readdata <= UNMAPPED_RD;
        end else if (ce_i) begin
            rd_pend <= avs_read && !rd_pend;
            if (avs_read && !rd_pend) begin
                unique case (avs_address)
                    OFF_CTRL:     avs_readdata <= ctrl;
                    OFF_PRE_LIM:  avs_readdata <= pre_lim;
                    OFF_UV_LIM:   avs_readdata <= uv_lim;
                    OFF_CUT_LIM:  avs_readdata <= cut_lim;
                    OFF_HYST:     avs_readdata <= hyst;
                    OFF_TEMP_LIM: avs_readdata <= temp_lim;
                    OFF_CUR_LIM:  avs_readdata <= cur_lim;
                    OFF_DELAY:    avs_readdata <= dly;
                    OFF_SYS_LIM:  avs_readdata <= sys_lim;
                    OFF_STATUS:   avs_readdata <= {24'h0000_00,
                                     1'b0, balance_en_o, safety,
                                     forced, 1'b0, drive_o};
                    OFF_IRQ_STAT: avs_readdata <= {{(32-NUM_EV){1'b0}},
                                                   irq_stat};
                    OFF_IRQ_MASK: avs_readdata <= {{(32-NUM_EV){1'b0}},
                                                   irq_mask};
                    default:      avs_readdata <= UNMAPPED_RD;
                endcase
            end
        end
    end
endmodule : pfc_fet_ctrl

// ---- pfc_gate_shift.sv ----
// partner model: inverting level shifters in front of the switch gates
`timescale 1ns/1ns
module pfc_gate_shift
    import pfc_pkg::*;
(
    input  wire pfc_drive_s drive_i,
    output      pfc_drive_s gate_n_o
);
    // one transistor per switch, so a high drive pulls its gate line low
    assign gate_n_o = ~drive_i;
endmodule : pfc_gate_shift

// ---- pfc_fet_ctrl_assertions.sv ----
// checker: switch drives tied in time to their forcing causes
`timescale 1ns/1ns
module pfc_fet_ctrl_chk
    import pfc_pkg::*;
#(
    parameter int NUM_FORCE = 2
) (
    input wire logic                 clk_i,
    input wire logic                 resetn_i,
    input wire logic                 ce_i,
    input wire logic [5:0]           avs_address,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic [3:0]           avs_byteenable,
    input wire pfc_meas_s            meas_i,
    input wire logic                 hw_overcurrent_i,
    input wire logic                 hw_short_i,
    input wire logic [NUM_FORCE-1:0] external_switch_force_in_i,
    input wire pfc_drive_s           drive_o,
    input wire logic                 balance_en_o,
    input wire logic                 temp_rate_en_o
);
    logic [7:0] ctl;
    logic       go;
    // ------------------------------------------------------------
    // control byte shadow
    // ------------------------------------------------------------
    // polarity and options live in a register, so follow its writes
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl <= CTRL_RST[7:0];
        end else if (ce_i && avs_write && avs_address == OFF_CTRL
                     && avs_byteenable[0]) begin
            ctl <= avs_writedata[7:0];
        end
    end
    // skip write cycles; the shadow takes each write on the same edge as ctrl
    assign go = ce_i && !avs_write;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_HW_OC: assert property (
        ce_i && hw_overcurrent_i |=> drive_o == '0)
        else $error("drives on after overcurrent trip");
    AST_HW_SC: assert property (
        ce_i && $rose(hw_short_i) |=> drive_o == '0)
        else $error("drives on after short trip");
    AST_EN_OFF: assert property (
        go && !ctl[CTRL_ENABLE] |=> drive_o == '0)
        else $error("drives on while block disabled");
    AST_FORCE_HI: assert property (
        go && ctl[0] && external_switch_force_in_i[0] |-> ##1 drive_o == '0)
        else $error("drives on under high force input");
    AST_FORCE_LO: assert property (
        go && !ctl[1] && !external_switch_force_in_i[1] |=> drive_o == '0)
        else $error("drives on under low force input");
    AST_HA_RATE: assert property (
        go && ctl[CTRL_HIGH_AVAIL] |=> !temp_rate_en_o)
        else $error("rate of rise on in high availability");
    AST_BAL_CHG: assert property (
        (go && ctl[CTRL_BAL_NO_CHG]
         && $signed(meas_i.current) > 16'sh00c8)[*3] |=> !balance_en_o)
        else $error("balancing while charging");
    AST_BAL_DSG: assert property (
        (go && ctl[CTRL_BAL_NO_DSG]
         && $signed(meas_i.current) < 16'shff38)[*3] |=> !balance_en_o)
        else $error("balancing while discharging");
endmodule : pfc_fet_ctrl_chk

bind pfc_fet_ctrl pfc_fet_ctrl_chk #(.NUM_FORCE(NUM_FORCE)) i_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .meas_i(meas_i), .hw_overcurrent_i(hw_overcurrent_i),
    .hw_short_i(hw_short_i),
    .external_switch_force_in_i(external_switch_force_in_i),
    .drive_o(drive_o), .balance_en_o(balance_en_o),
    .temp_rate_en_o(temp_rate_en_o));

// ---- pack_protection_fet_control_tb_top.sv ----
// testbench: switch decisions, registers and interrupt of the fet control
`timescale 1ns/1ns
module pack_protection_fet_control_tb_top
    import pfc_pkg::*;
;
    localparam logic [15:0] NV = 16'h0bb8;
    localparam logic [15:0] TN = 16'h0019;
    localparam logic [15:0] Z  = 16'h0000;
    logic        clk_i    = 1'b0;
    logic        resetn_i = 1'b0;
    logic [5:0]  adr      = 6'h00;
    logic        rd_en    = 1'b0;
    logic        wr_en    = 1'b0;
    logic [31:0] wdat     = 32'h0000_0000;
    logic [31:0] rdat;
    logic        wait_req;
    pfc_meas_s   meas     = '{NV, NV, 16'h8000, TN, Z};
    logic        hw_oc    = 1'b0;
    logic        hw_sc    = 1'b0;
    logic [1:0]  force_in = 2'b11;
    pfc_drive_s  drive;
    pfc_drive_s  gate_n;
    logic        bal, pump, trate, irq;
    logic [2:0]  snap;
    logic [31:0] q;
    int          fails = 0;
    int          comparisons = 0;
    int          n;
    logic [5:0]  cfg_a [8] = '{OFF_PRE_LIM, OFF_UV_LIM, OFF_CUT_LIM,
        OFF_HYST, OFF_TEMP_LIM, OFF_CUR_LIM, OFF_SYS_LIM, OFF_DELAY};
    logic [31:0] cfg_d [8] = '{32'h0000_0064, 32'h0000_00c8, 32'h0000_0fa0,
        32'h0000_0064, 32'h0050_000a, 32'h01f4_01f4, 32'hffff_0000,
        32'h0000_0005};

    // free running 100 MHz clock
    always #5 clk_i = ~clk_i;

    pfc_fet_ctrl #(.NUM_FORCE(2), .DLY_W(16)) i_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdat), .avs_byteenable(4'hf),
        .avs_readdata(rdat), .avs_waitrequest(wait_req),
        .meas_i(meas), .hw_overcurrent_i(hw_oc), .hw_short_i(hw_sc),
        .external_switch_force_in_i(force_in), .drive_o(drive),
        .balance_en_o(bal), .pump_on_o(pump), .temp_rate_en_o(trate),
        .irq_o(irq));
    pfc_gate_shift i_shift (.drive_i(drive), .gate_n_o(gate_n));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string s, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", s, e, g);
            fails++;
        end
    endtask : chk
    // request stands until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        wr_en <= w;
        rd_en <= !w;
        adr   <= a;
        wdat  <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        if (k >= 50) begin
            fails++;
            stop_test();
        end
        r = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, q);
        chk("readdata", e, q);
    endtask : rd
    // apply measurements, wait, then compare masked drives and gates
    task automatic mv(input logic [15:0] lo, hi, tc, cur, input int cyc,
                      input logic [2:0] e, m);
        logic [2:0] ne;
        ne = ~e;
        meas <= '{lo, hi, 16'h8000, tc, cur};
        repeat (cyc) @(posedge clk_i);
        @(negedge clk_i);
        snap = {bal, trate, irq};
        chk("drive", e & m, drive & m);
        chk("gate", ne & m, gate_n & m);
        @(posedge clk_i);
    endtask : mv

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rd(OFF_CTRL, CTRL_RST);
        rd(OFF_DELAY, DELAY_RST);
        rd(OFF_CUT_LIM, LIMIT_RST);
        wr(6'h30, 32'hffff_ffff);
        rd(6'h30, UNMAPPED_RD);
        for (int i = 0; i < 8; i++) wr(cfg_a[i], cfg_d[i]);
        rd(OFF_HYST, 32'h0000_0064);
        $display("test registers done");
        mv(NV, NV, TN, Z, 3, 3'b111, 3'b111);
        mv(16'h0032, NV, TN, Z, 3, 3'b100, 3'b111);
        mv(16'h00fa, NV, TN, Z, 3, 3'b100, 3'b111);
        mv(16'h015e, NV, TN, Z, 3, 3'b111, 3'b111);
        mv(NV, 16'h1000, TN, Z, 3, 3'b000, 3'b110);
        mv(NV, NV, TN, Z, 3, 3'b111, 3'b111);
        mv(NV, NV, 16'h005a, Z, 1, 3'b111, 3'b111);
        mv(NV, NV, 16'h005a, Z, 10, 3'b000, 3'b110);
        mv(NV, NV, TN, Z, 12, 3'b111, 3'b111);
        $display("test voltage and temperature done");
        mv(NV, NV, TN, 16'h012c, 4, 3'b111, 3'b111);
        mv(NV, NV, TN, 16'hfed4, 4, 3'b111, 3'b111);
        mv(NV, NV, TN, 16'hfda8, 14, 3'b000, 3'b001);
        mv(NV, NV, TN, Z, 14, 3'b111, 3'b111);
        wr(OFF_CTRL, 32'h0000_0028);
        mv(NV, NV, TN, 16'h012c, 6, 3'b000, 3'b000);
        chk("balance", 1'b0, snap[2]);
        wr(OFF_CTRL, 32'h0000_0024);
        mv(NV, NV, TN, 16'hfed4, 6, 3'b000, 3'b000);
        chk("balance", 1'b0, snap[2]);
        wr(OFF_CTRL, 32'h0000_0030);
        mv(NV, NV, TN, Z, 4, 3'b111, 3'b111);
        chk("temp_rate", 1'b0, snap[1]);
        n = 0;
        repeat (100) begin
            @(negedge clk_i);
            n += pump;
        end
        @(posedge clk_i);
        chk("pump_count", PUMP_DUTY_HIGH, n);
        wr(OFF_CTRL, 32'h0000_0020);
        $display("test current and balancing done");
        force_in <= 2'b10;
        mv(NV, NV, TN, Z, 3, 3'b000, 3'b111);
        force_in <= 2'b01;
        mv(NV, NV, TN, Z, 3, 3'b000, 3'b111);
        wr(OFF_CTRL, 32'h0000_0023);
        force_in <= 2'b11;
        mv(NV, NV, TN, Z, 3, 3'b000, 3'b111);
        force_in <= 2'b00;
        mv(NV, NV, TN, Z, 3, 3'b111, 3'b111);
        $display("test force inputs done");
        wr(OFF_IRQ_MASK, 32'h0000_0010);
        bus(1'b0, OFF_IRQ_STAT, 32'h0000_0000, q);
        hw_oc <= 1'b1;
        mv(NV, NV, TN, Z, 3, 3'b000, 3'b111);
        chk("irq", 1'b1, snap[0]);
        hw_oc <= 1'b0;
        hw_sc <= 1'b1;
        mv(NV, NV, TN, Z, 3, 3'b000, 3'b111);
        hw_sc <= 1'b0;
        mv(NV, NV, TN, Z, 3, 3'b111, 3'b111);
        rd(OFF_IRQ_STAT, 32'h0000_0010);
        mv(NV, NV, TN, Z, 1, 3'b111, 3'b111);
        chk("irq", 1'b0, snap[0]);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        hw_oc <= 1'b1;
        mv(NV, NV, TN, Z, 3, 3'b000, 3'b111);
        chk("irq", 1'b0, snap[0]);
        hw_oc <= 1'b0;
        wr(OFF_CTRL, 32'h0000_0003);
        mv(NV, NV, TN, Z, 3, 3'b000, 3'b111);
        $display("test trips and interrupt done");
        stop_test();
    end
endmodule : pack_protection_fet_control_tb_top
